// ===== bank_select_word_address_latch.sv
// Purpose: address front end of one core memory bank
// Assumes: all inputs synchronous to core_clk
// Notes: straps are configuration bits written over AHB-Lite
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "bank_regs.svh"

module bank_select_word_address_latch (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // memory bus side
  input wire logic [`BUS_ADDR_W-1:0] bus_addr,
  input wire logic dc_power_low,
  input wire logic cycle_type_bit0,
  input wire logic cycle_type_bit1,
  input wire logic transfer_request,
  // control logic timing
  input wire logic word_reg_clk,
  input wire logic read_timing_pulse,
  input wire logic write_timing_pulse,
  // control logic results
  output logic bank_select,
  output logic cycle_start,
  output logic read_transfer,
  output logic switch_strobe,
  output logic driver_strobe,
  // array decoder drive
  output bank_pkg::array_drive_t array_drive
);
  import bank_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic wr_pending;
    logic [`OFFSET_MSB:0] wr_offset;
    strap_cfg_t straps;
    logic reg_clk_prev;
    logic bank_select;
    logic cycle_start;
    logic read_transfer;
    logic switch_strobe;
    logic driver_strobe;
    logic [1:0] driver_bits;
    logic [5:0] predecode_n;
    logic power_low;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;

  logic bank_match;
  logic low_word_address_bit;
  logic word_load;
  logic [`WORD_ADDR_W-1:0] word_in;
  logic [`WORD_ADDR_W-1:0] word_q;
  logic [`WORD_ADDR_W-1:0] word_n;
  logic read_op;
  logic sw_next;
  logic drv_next;
  logic addr_phase;
  logic [`OFFSET_MSB:0] rd_offset;
  logic [31:0] rd_value;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // comparator network
  // ----------------------------------------------------------------
  bank_matcher u_matcher (
    .bus_addr(bus_addr),
    .dc_power_low(dc_power_low),
    .straps(state_reg.straps),
    .bank_match(bank_match),
    .low_word_address_bit(low_word_address_bit)
  );

  // ----------------------------------------------------------------
  // word address register
  // ----------------------------------------------------------------
  always_comb begin
    // rising edge of the register clock from the control logic
    word_load = word_reg_clk & ~state_reg.reg_clk_prev;
    // bits 13..2 straight from receivers, bit 1 via the selector
    word_in = {bus_addr[`WORD_MSB:`LOW_WORD_BIT + 1], low_word_address_bit};
    word_n = word_load ? word_in : word_q;
  end

  word_address_reg u_word (
    .core_clk(core_clk),
    .load(word_load),
    .word_in(word_in),
    .word_out(word_q)
  );

  // ----------------------------------------------------------------
  // timing strobes
  // ----------------------------------------------------------------
  always_comb begin
    // test strap forces read whatever the cycle type lines hold
    read_op = state_reg.straps.read_only_test_strap | ~cycle_type_bit1;
    sw_next = (read_op & read_timing_pulse) | (~read_op & write_timing_pulse);
    drv_next = (read_op & write_timing_pulse) | (~read_op & read_timing_pulse);
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    addr_phase = hsel & htrans[`HTRANS_ACTIVE_BIT] & hready;
    rd_offset = haddr[`OFFSET_MSB:0];
    status_word = 32'h0000_0000;
    status_word[`ST_SELECT_BIT] = state_reg.bank_select;
    status_word[`ST_READ_BIT] = state_reg.read_transfer;
    status_word[`ST_SWITCH_BIT] = state_reg.switch_strobe;
    status_word[`ST_DRIVER_BIT] = state_reg.driver_strobe;
    status_word[`ST_POWER_BIT] = state_reg.power_low;
    status_word[`ST_CYCLE_BIT] = state_reg.cycle_start;
    case (rd_offset)
      `CFG_OFFSET: begin
        rd_value = {26'h0, state_reg.straps};
      end
      `STATUS_OFFSET: begin
        rd_value = status_word;
      end
      `WORD_OFFSET: begin
        rd_value = {19'h0, word_q};
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.hreadyout = 1'b1;
    state_next.reg_clk_prev = word_reg_clk;

    // bus slave: read data loaded at the address phase edge
    state_next.wr_pending = 1'b0;
    if (addr_phase) begin
      state_next.wr_pending = hwrite;
      state_next.wr_offset = rd_offset;
      if (!hwrite) begin
        state_next.hrdata = rd_value;
      end
    end
    if (state_reg.wr_pending && state_reg.wr_offset == `CFG_OFFSET) begin
      // slot straps pick one of sixteen 8K-word banks
      state_next.straps.bank_straps = hwdata[`CFG_BANK_MSB:`CFG_BANK_LSB];
      state_next.straps.fixed_match_strap = hwdata[`CFG_FIXED_BIT];
      state_next.straps.read_only_test_strap = hwdata[`CFG_TEST_BIT];
    end

    // bank select and cycle start
    state_next.bank_select = bank_match;
    state_next.power_low = dc_power_low;
    state_next.cycle_start = transfer_request & bank_match;
    state_next.read_transfer = read_op;

    // strobes and gated decoder inputs
    state_next.switch_strobe = sw_next;
    state_next.driver_strobe = drv_next;
    state_next.driver_bits[0] = word_n[3 - 1] & drv_next;
    state_next.driver_bits[1] = word_n[9 - 1] & drv_next;
    state_next.predecode_n[0] = ~(sw_next & word_n[6 - 1]);
    state_next.predecode_n[1] = ~(sw_next & ~word_n[6 - 1]);
    state_next.predecode_n[2] = ~(sw_next & word_n[12 - 1] & word_n[13 - 1]);
    state_next.predecode_n[3] = ~(sw_next & ~word_n[12 - 1] & word_n[13 - 1]);
    state_next.predecode_n[4] = ~(sw_next & word_n[12 - 1] & ~word_n[13 - 1]);
    state_next.predecode_n[5] = ~(sw_next & ~word_n[12 - 1] & ~word_n[13 - 1]);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg.hreadyout <= 1'b1;
      state_reg.hrdata <= 32'h0000_0000;
      state_reg.wr_pending <= 1'b0;
      state_reg.wr_offset <= 12'h000;
      state_reg.straps.bank_straps <= `CFG_BANK_RESET;
      state_reg.straps.fixed_match_strap <= `CFG_FIXED_RESET;
      state_reg.straps.read_only_test_strap <= `CFG_TEST_RESET;
      state_reg.reg_clk_prev <= 1'b0;
      state_reg.bank_select <= 1'b0;
      state_reg.cycle_start <= 1'b0;
      state_reg.read_transfer <= 1'b0;
      state_reg.switch_strobe <= 1'b0;
      state_reg.driver_strobe <= 1'b0;
      state_reg.driver_bits <= 2'h0;
      state_reg.predecode_n <= 6'h3F;
      state_reg.power_low <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = state_reg.hreadyout;
  assign hresp = `HRESP_OKAY;
  assign hrdata = state_reg.hrdata;
  assign bank_select = state_reg.bank_select;
  assign cycle_start = state_reg.cycle_start;
  assign read_transfer = state_reg.read_transfer;
  assign switch_strobe = state_reg.switch_strobe;
  assign driver_strobe = state_reg.driver_strobe;
  // direct decoder bits straight from the word register
  assign array_drive.direct_bits = {word_q[11 - 1], word_q[10 - 1], word_q[8 - 1],
    word_q[7 - 1], word_q[5 - 1], word_q[4 - 1], word_q[2 - 1], word_q[1 - 1]};
  assign array_drive.driver_bits = state_reg.driver_bits;
  assign array_drive.predecode_n = state_reg.predecode_n;

endmodule

// ===== bank_regs.svh
// Purpose: named offsets, field positions, reset values and codes
// Assumes: included by the package and the design modules
// Notes: byte addresses on a 32-bit AHB-Lite slave
`ifndef BANK_SELECT_REGS_SVH
`define BANK_SELECT_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CFG_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define WORD_OFFSET 12'h008
`define OFFSET_MSB 11
`define OFFSET_LSB 2

// ----------------------------------------------------------------
// config fields (1 = strap installed)
// ----------------------------------------------------------------
`define CFG_BANK_LSB 0
`define CFG_BANK_MSB 3
`define CFG_FIXED_BIT 4
`define CFG_TEST_BIT 5
`define CFG_BANK_RESET 4'hF
`define CFG_FIXED_RESET 1'h1
`define CFG_TEST_RESET 1'h0

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define ST_SELECT_BIT 0
`define ST_READ_BIT 1
`define ST_SWITCH_BIT 2
`define ST_DRIVER_BIT 3
`define ST_POWER_BIT 4
`define ST_CYCLE_BIT 5

// ----------------------------------------------------------------
// memory bus address layout and cycle codes
// ----------------------------------------------------------------
`define BUS_ADDR_W 18
`define BANK_MSB 17
`define BANK_LSB 14
`define WORD_ADDR_W 13
`define WORD_MSB 13
`define LOW_WORD_BIT 1
`define CYCLE_WRITE_BIT 1
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'h0

`endif

// ===== bank_pkg.sv
// Purpose: shared types of the bank select and word address latch
// Assumes: bank_regs.svh holds the word address width; the other field widths are written here
// Notes: types only
`include "bank_regs.svh"

package bank_pkg;

  // ----------------------------------------------------------------
  // strap settings
  // ----------------------------------------------------------------
  typedef struct packed {
    logic read_only_test_strap;
    logic fixed_match_strap;
    logic [3:0] bank_straps;
  } strap_cfg_t;

  // ----------------------------------------------------------------
  // word register state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`WORD_ADDR_W-1:0] word;
  } word_state_t;

  // ----------------------------------------------------------------
  // array drive group
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] direct_bits;
    logic [1:0] driver_bits;
    logic [5:0] predecode_n;
  } array_drive_t;

endpackage

// ===== bank_matcher.sv
// Purpose: strapped comparator network producing the bank match
// Assumes: straps high when installed
// Notes: combinational, registered by the caller
`timescale 1ns/1ps
`include "bank_regs.svh"

module bank_matcher (
  // address from the bus receivers
  input wire logic [`BUS_ADDR_W-1:0] bus_addr,
  input wire logic dc_power_low,
  // strap settings
  input wire bank_pkg::strap_cfg_t straps,
  // results
  output logic bank_match,
  output logic low_word_address_bit
);
  import bank_pkg::*;

  logic [3:0] bit_match;
  logic spare_match;

  always_comb begin
    // installed strap wants 0, removed strap wants 1
    bit_match = bus_addr[`BANK_MSB:`BANK_LSB] ^ straps.bank_straps;
    // spare receiver output held low, matches only with strap in
    spare_match = straps.fixed_match_strap;
    // every bit must match, power low blocks the select
    bank_match = (&bit_match) & spare_match & ~dc_power_low;
    // bit 1 routed through the selector
    low_word_address_bit = bus_addr[`LOW_WORD_BIT];
  end

endmodule

// ===== word_address_reg.sv
// Purpose: 13-bit word address register
// Assumes: load high for one cycle at a register clock rising edge
// Notes: no reset, contents unknown until the first load
`timescale 1ns/1ps
`include "bank_regs.svh"

module word_address_reg (
  // clock
  input wire logic core_clk,
  // load
  input wire logic load,
  input wire logic [`WORD_ADDR_W-1:0] word_in,
  // contents
  output logic [`WORD_ADDR_W-1:0] word_out
);
  import bank_pkg::*;

  word_state_t state_reg;
  word_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.word = word_in;
    end
  end

  // no preset or clear
  always_ff @(posedge core_clk) begin
    state_reg <= state_next;
  end

  assign word_out = state_reg.word;

endmodule

// ===== host_master.sv
// Purpose: host bus master on the memory side of the bank
// Assumes: one request is held until the next is placed
// Notes: released address lines show the inverse of the last value
`timescale 1ns/1ps
module host_master (
  // clock
  input wire logic core_clk,
  // memory bus
  output logic [17:0] bus_addr,
  output logic cycle_type_bit0,
  output logic cycle_type_bit1,
  output logic transfer_request,
  output logic dc_power_low
);
  initial begin
    bus_addr = 18'h0;
    cycle_type_bit0 = 1'h0;
    cycle_type_bit1 = 1'h0;
    transfer_request = 1'h0;
    dc_power_low = 1'h0;
  end
  // place a request and hold it until the next one
  task automatic put(input logic [17:0] adr, input logic wr, input logic pl);
    @(posedge core_clk);
    bus_addr <= adr;
    cycle_type_bit1 <= wr;
    cycle_type_bit0 <= 1'h0;
    transfer_request <= 1'h1;
    dc_power_low <= pl;
  endtask
  // release the bus
  task automatic drop;
    transfer_request <= 1'h0;
    bus_addr <= ~bus_addr;
  endtask
endmodule

// ===== bank_select_monitor.sv
// Purpose: port checks of the bank select and word latch
// Assumes: bound to the top module
// Notes: straps are internal, so outputs are tied to each other
`timescale 1ns/1ps
`include "bank_regs.svh"
module bank_select_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // memory side inputs
  input wire logic [`BUS_ADDR_W-1:0] bus_addr,
  input wire logic dc_power_low,
  input wire logic cycle_type_bit1,
  input wire logic transfer_request,
  input wire logic word_reg_clk,
  input wire logic read_timing_pulse,
  input wire logic write_timing_pulse,
  // results
  input wire logic bank_select,
  input wire logic cycle_start,
  input wire logic read_transfer,
  input wire logic switch_strobe,
  input wire logic driver_strobe,
  input wire bank_pkg::array_drive_t array_drive
);
  import bank_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  a_power_blocks: assert property ($past(dc_power_low) |-> !bank_select)
    else $error("bank select during power low");
  a_start_needs_select: assert property (cycle_start |-> bank_select)
    else $error("cycle start without bank select");
  a_start_follows: assert property (cycle_start == ($past(transfer_request) && bank_select))
    else $error("cycle start not from request and select");
  a_read_default: assert property ($past(reset_n) && !$past(cycle_type_bit1) |-> read_transfer)
    else $error("read cycle type not seen as read");
  a_switch_strobe: assert property (switch_strobe == (($past(read_timing_pulse) && read_transfer)
    || ($past(write_timing_pulse) && !read_transfer)))
    else $error("switch strobe wrong");
  a_driver_strobe: assert property (driver_strobe == (($past(write_timing_pulse) && read_transfer)
    || ($past(read_timing_pulse) && !read_transfer)))
    else $error("driver strobe wrong");
  a_predecode_idle: assert property (!switch_strobe |-> array_drive.predecode_n == 6'h3F)
    else $error("predecode active without switch strobe");
  a_predecode_pick: assert property (switch_strobe |-> $countones(~array_drive.predecode_n) == 2)
    else $error("predecode not one per group");
  a_driver_idle: assert property (!driver_strobe |-> array_drive.driver_bits == 2'h0)
    else $error("driver bits without driver strobe");
  a_word_load: assert property ($past(word_reg_clk) && !$past(word_reg_clk, 2) |->
    array_drive.direct_bits == {$past(bus_addr[11:10]), $past(bus_addr[8:7]),
    $past(bus_addr[5:4]), $past(bus_addr[2:1])})
    else $error("direct bits not the loaded address");
endmodule

// ===== bank_select_word_address_latch_tb.sv
// Purpose: self-checking bench of the bank select and word latch
// Assumes: zero wait state register bus
// Notes: table of strap cases, then hand-written cases
`timescale 1ns/1ps
`include "bank_regs.svh"
module bank_select_word_address_latch_tb;
  import bank_pkg::*;
  typedef struct packed {logic [5:0] cfg; logic [3:0] slot; logic pwr; logic sel;} row_t;
  logic core_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, word_reg_clk;
  logic read_timing_pulse, write_timing_pulse, cycle_type_bit0, cycle_type_bit1;
  logic transfer_request, dc_power_low, bank_select, cycle_start, read_transfer;
  logic switch_strobe, driver_strobe;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [17:0] bus_addr, a;
  logic [5:0] pre;
  array_drive_t array_drive;
  int fail_count, samples_checked, n;
  row_t rows [8] = '{'{6'h1F, 4'h0, 1'h0, 1'h1}, '{6'h1E, 4'h1, 1'h0, 1'h1},
    '{6'h1E, 4'h0, 1'h0, 1'h0}, '{6'h10, 4'hF, 1'h0, 1'h1}, '{6'h10, 4'h7, 1'h0, 1'h0},
    '{6'h1F, 4'h0, 1'h1, 1'h0}, '{6'h0F, 4'h0, 1'h0, 1'h0}, '{6'h17, 4'h8, 1'h0, 1'h1}};
  assign hready = hreadyout;
  always #12.5 core_clk = ~core_clk;
  host_master u_host (.core_clk, .bus_addr, .cycle_type_bit0, .cycle_type_bit1,
    .transfer_request, .dc_power_low);
  bank_select_word_address_latch u_dut (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .bus_addr, .dc_power_low,
    .cycle_type_bit0, .cycle_type_bit1, .transfer_request, .word_reg_clk, .read_timing_pulse,
    .write_timing_pulse, .bank_select, .cycle_start, .read_transfer, .switch_strobe,
    .driver_strobe, .array_drive);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ready_wait;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'h1 && n < 64);
    if (hready !== 1'h1) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] adr, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= adr;
    hwrite <= w;
    ready_wait();
    htrans <= 2'h0;
    hwdata <= d;
    ready_wait();
    rd = hrdata;
  endtask
  initial begin
    core_clk = 1'h0;
    reset_n = 1'h0;
    {hsel, hwrite, word_reg_clk, read_timing_pulse, write_timing_pulse} = 5'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    fail_count = 0;
    samples_checked = 0;
    a = 18'h02D6A;
    pre = ~{~a[12] & ~a[13], a[12] & ~a[13], ~a[12] & a[13], a[12] & a[13], ~a[6], a[6]};
    repeat (4) @(posedge core_clk);
    reset_n <= 1'h1;
    bus(1'h0, `CFG_OFFSET, 32'h0);
    chk(rd, 32'h1F);
    chk(hresp, `HRESP_OKAY);
    bus(1'h1, 32'h0000000C, 32'hFFFFFFFF);
    bus(1'h0, 32'h0000000C, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1'h1, `CFG_OFFSET, {26'h0, rows[i].cfg});
      u_host.put({rows[i].slot, 14'h1555}, 1'h0, rows[i].pwr);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk(bank_select, rows[i].sel);
      chk(cycle_start, rows[i].sel);
      @(posedge core_clk);
      bus(1'h0, `STATUS_OFFSET, 32'h0);
      chk(rd[`ST_SELECT_BIT], rows[i].sel);
    end
    bus(1'h1, `CFG_OFFSET, 32'h1F);
    u_host.put(a, 1'h0, 1'h0);
    @(posedge core_clk);
    word_reg_clk <= 1'h1;
    @(posedge core_clk);
    word_reg_clk <= 1'h0;
    u_host.drop();
    @(posedge core_clk);
    @(negedge core_clk);
    chk(array_drive.direct_bits, {a[11:10], a[8:7], a[5:4], a[2:1]});
    @(posedge core_clk);
    bus(1'h0, `WORD_OFFSET, 32'h0);
    chk(rd, {19'h0, a[13:1]});
    for (int k = 0; k < 4; k++) begin
      u_host.put(a, k[1], 1'h0);
      @(posedge core_clk);
      read_timing_pulse <= ~k[0];
      write_timing_pulse <= k[0];
      @(posedge core_clk);
      read_timing_pulse <= 1'h0;
      write_timing_pulse <= 1'h0;
      @(negedge core_clk);
      chk(switch_strobe, k[1] == k[0]);
      chk(driver_strobe, k[1] != k[0]);
      chk(array_drive.predecode_n, k[1] == k[0] ? pre : 6'h3F);
      chk(array_drive.driver_bits, k[1] != k[0] ? {a[9], a[3]} : 2'h0);
      chk(read_transfer, !k[1]);
    end
    @(posedge core_clk);
    bus(1'h1, `CFG_OFFSET, 32'h3F);
    u_host.put(a, 1'h1, 1'h0);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(read_transfer, 1'h1);
    @(posedge core_clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(bank_select, 1'h0);
    chk(array_drive.direct_bits, {a[11:10], a[8:7], a[5:4], a[2:1]});
    @(posedge core_clk);
    reset_n <= 1'h1;
    bus(1'h0, `CFG_OFFSET, 32'h0);
    chk(rd, 32'h1F);
    wrap_up();
  end
endmodule
bind bank_select_word_address_latch bank_select_monitor u_mon (.core_clk, .reset_n, .bus_addr,
  .dc_power_low, .cycle_type_bit1, .transfer_request, .word_reg_clk, .read_timing_pulse,
  .write_timing_pulse, .bank_select, .cycle_start, .read_transfer, .switch_strobe,
  .driver_strobe, .array_drive);
